// File: logic/cmbc_pkg.sv
// Package with constants for the CPU module bus control block
package cmbc_pkg;
    // Counter preset and decode points over a 10-count cycle of the 20 MHz oscillator
    localparam logic [3:0] CNT_PRESET   = 4'h6;   // Counts 6..15, wraps to preset
    localparam logic [3:0] CNT_LAST     = 4'hf;
    localparam logic [3:0] PH1_START    = 4'h6;   // Phase one high for 2 counts
    localparam logic [3:0] PH1_END      = 4'h7;
    localparam logic [3:0] PH2_START    = 4'h9;   // Phase two high for 5 counts
    localparam logic [3:0] PH2_END      = 4'hd;
    localparam logic [3:0] EARLY_PH1    = 4'h5;   // Unused slot never hit; see early decode
    localparam logic [3:0] EARLY_CNT    = 4'hf;   // Early phase one leads phase one by 1 count
    // Oscillator enable divider: 40 MHz reference halved to 20 MHz
    localparam int         OSC_DIV      = 2;
    localparam logic [0:0] OSC_DIV_LAST = 1'h1;
    // Status byte bit positions
    localparam int ST_IRQ_ACK_CMD = 0;
    localparam int ST_WO_N = 1;
    localparam int ST_STACK = 2;
    localparam int ST_HLTA = 3;
    localparam int ST_OUT  = 4;
    localparam int ST_M1   = 5;
    localparam int ST_INP  = 6;
    localparam int ST_MEMR = 7;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // Power-on reset count; the processor is released once the counter reaches it
    localparam logic [3:0] POR_LAST   = 4'hf;
endpackage : cmbc_pkg

// File: logic/cmbc_status_latch.sv
// Eight-bit status latch loaded by the status load pulse
`timescale 1ns/1ps
module cmbc_status_latch (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Load side
    input  wire logic       load,
    input  wire logic [7:0] din,
    // Latched status
    output logic      [7:0] status
);
    logic [7:0] status_q;
    logic [7:0] status_d;

    // Hold until next load
    always_comb begin
        status_d = status_q;
        if (load) begin
            status_d = din;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_q <= cmbc_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    assign status = status_q;
endmodule : cmbc_status_latch

// File: logic/cmbc_top.sv
// CPU module clock generator, data bus buffer and system control logic
`timescale 1ns/1ps
module cmbc_top (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Processor clocks and timing
    output logic            phase_one,
    output logic            phase_two,
    output logic            early_phase_one,
    output logic            status_load_pulse,
    // Processor handshakes
    input  wire logic       cycle_begin,
    input  wire logic       read_window,
    input  wire logic       store_strobe_n,
    output logic            cpu_reset,
    // Processor-side data pins
    input  wire logic [7:0] cpu_data_in,
    output logic      [7:0] cpu_data_out,
    output logic            cpu_data_oe,
    // System-side data pins
    input  wire logic [7:0] sys_data_in,
    output logic      [7:0] sys_data_out,
    output logic            sys_data_oe,
    // DMA bus release
    input  wire logic       bus_release_n,
    // External requests and their synchronised forms
    input  wire logic       hold_req,
    input  wire logic       ready_req,
    output logic            hold_sync,
    output logic            ready_sync,
    // Single step
    input  wire logic       step_mode,
    input  wire logic       step_go,
    // Control bus commands, active low, then direction select and status bits
    output logic            mem_read_n,
    output logic            mem_write_n,
    output logic            port_read_n,
    output logic            port_write_n,
    output logic            irq_ack_cmd_n,
    output logic            direction_select,
    output logic            status_m1,
    output logic            status_stack
);
    // Oscillator enable and counter state
    logic        osc_q;
    logic        osc_d;
    logic [3:0]  cnt_q;
    logic [3:0]  cnt_d;
    logic        osc_en;
    // Clock outputs registered so they are glitch free
    logic        ph1_q;
    logic        ph1_d;
    logic        ph2_q;
    logic        ph2_d;
    logic        eph1_q;
    logic        eph1_d;
    logic        stb_q;
    logic        stb_d;
    // Request sync, reset and step state
    logic        hold_q;
    logic        hold_d;
    logic        rdy_q;
    logic        rdy_d;
    logic [3:0]  por_q;
    logic [3:0]  por_d;
    logic        step_arm_q;
    logic        step_arm_d;
    logic        step_prev_q;
    logic        step_prev_d;
    // Latched status and bus buffer state
    logic [7:0]  status;
    logic [7:0]  cpu_out_q;
    logic [7:0]  cpu_out_d;
    logic [7:0]  sys_out_q;
    logic [7:0]  sys_out_d;
    logic        cpu_oe_q;
    logic        cpu_oe_d;
    logic        sys_oe_q;
    logic        sys_oe_d;
    logic        mr_q;
    logic        mr_d;
    logic        mw_q;
    logic        mw_d;
    logic        pr_q;
    logic        pr_d;
    logic        pw_q;
    logic        pw_d;
    logic        ia_q;
    logic        ia_d;
    logic        bus_on;

    assign osc_en = (osc_q == cmbc_pkg::OSC_DIV_LAST);
    assign bus_on = !bus_release_n ? 1'b0 : 1'b1;

    // Oscillator divider and presettable counter
    always_comb begin
        osc_d = osc_q + 1'b1;
        cnt_d = cnt_q;
        if (osc_en) begin
            if (cnt_q == cmbc_pkg::CNT_LAST) begin
                cnt_d = cmbc_pkg::CNT_PRESET;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    // Phase decode from disjoint count ranges, so the phases cannot overlap
    always_comb begin
        ph1_d  = (cnt_d >= cmbc_pkg::PH1_START) && (cnt_d <= cmbc_pkg::PH1_END);
        ph2_d  = (cnt_d >= cmbc_pkg::PH2_START) && (cnt_d <= cmbc_pkg::PH2_END);
        eph1_d = (cnt_d == cmbc_pkg::EARLY_CNT);
        stb_d  = eph1_d && cycle_begin && osc_en;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            osc_q  <= 1'b0;
            cnt_q  <= cmbc_pkg::CNT_PRESET;
            ph1_q  <= 1'b0;
            ph2_q  <= 1'b0;
            eph1_q <= 1'b0;
            stb_q  <= 1'b0;
        end else begin
            osc_q  <= osc_d;
            cnt_q  <= cnt_d;
            ph1_q  <= ph1_d;
            ph2_q  <= ph2_d;
            eph1_q <= eph1_d;
            stb_q  <= stb_d;
        end
    end

    // Requests sampled on the early phase-one edge so they settle before phase one
    always_comb begin
        hold_d      = hold_q;
        rdy_d       = rdy_q;
        step_arm_d  = step_arm_q;
        step_prev_d = step_go;
        por_d       = (por_q == cmbc_pkg::POR_LAST) ? por_q : por_q + 4'h1;
        if (eph1_d && !eph1_q) begin
            hold_d = hold_req;
            rdy_d  = ready_req && (!step_mode || step_arm_q);
            if (step_mode && cycle_begin) begin
                step_arm_d = 1'b0;   // One machine cycle per step request
            end
        end
        // A press on the consuming edge wins over the clear and serves the next cycle
        if (step_go && !step_prev_q) begin
            step_arm_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hold_q      <= 1'b0;
            rdy_q       <= 1'b0;
            por_q       <= 4'h0;
            step_arm_q  <= 1'b0;
            step_prev_q <= 1'b0;
        end else begin
            hold_q      <= hold_d;
            rdy_q       <= rdy_d;
            por_q       <= por_d;
            step_arm_q  <= step_arm_d;
            step_prev_q <= step_prev_d;
        end
    end

    // Status comes from the processor-side pins, ahead of the buffer
    cmbc_status_latch u_status (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .load    (stb_d),
        .din     (cpu_data_in),
        .status  (status)
    );

    // Buffer direction and commands; enables and commands drop out during bus release
    always_comb begin
        cpu_oe_d  = bus_on && read_window;
        sys_oe_d  = bus_on && !read_window;
        cpu_out_d = sys_data_in;
        sys_out_d = cpu_data_in;
        mr_d = bus_on && read_window && status[cmbc_pkg::ST_MEMR];
        pr_d = bus_on && read_window && status[cmbc_pkg::ST_INP];
        ia_d = bus_on && read_window && status[cmbc_pkg::ST_IRQ_ACK_CMD];
        mw_d = bus_on && !store_strobe_n && !status[cmbc_pkg::ST_OUT];
        pw_d = bus_on && !store_strobe_n && status[cmbc_pkg::ST_OUT];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cpu_out_q <= 8'h00;
            sys_out_q <= 8'h00;
            cpu_oe_q  <= 1'b0;
            sys_oe_q  <= 1'b0;
            mr_q      <= 1'b0;
            mw_q      <= 1'b0;
            pr_q      <= 1'b0;
            pw_q      <= 1'b0;
            ia_q      <= 1'b0;
        end else begin
            cpu_out_q <= cpu_out_d;
            sys_out_q <= sys_out_d;
            cpu_oe_q  <= cpu_oe_d;
            sys_oe_q  <= sys_oe_d;
            mr_q      <= mr_d;
            mw_q      <= mw_d;
            pr_q      <= pr_d;
            pw_q      <= pw_d;
            ia_q      <= ia_d;
        end
    end

    // Outputs; each command is registered on the same edge as the buffer enables
    assign phase_one         = ph1_q;
    assign phase_two         = ph2_q;
    assign early_phase_one   = eph1_q;
    assign status_load_pulse = stb_q;
    assign cpu_reset         = (por_q != cmbc_pkg::POR_LAST);
    assign hold_sync         = hold_q;
    assign ready_sync        = rdy_q;
    assign cpu_data_out      = cpu_out_q;
    assign cpu_data_oe       = cpu_oe_q;
    assign sys_data_out      = sys_out_q;
    assign sys_data_oe       = sys_oe_q;
    assign direction_select  = read_window;
    assign mem_read_n        = !mr_q;
    assign mem_write_n       = !mw_q;
    assign port_read_n       = !pr_q;
    assign port_write_n      = !pw_q;
    assign irq_ack_cmd_n     = !ia_q;
    assign status_m1         = status[cmbc_pkg::ST_M1];
    assign status_stack      = status[cmbc_pkg::ST_STACK];
endmodule : cmbc_top

// File: tb/cmbc_chk.sv
// Port-level timing checker for the CPU module bus control block
`timescale 1ns/1ps
module cmbc_chk (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    // Clocks and strobes
    input wire logic       phase_one,
    input wire logic       phase_two,
    input wire logic       early_phase_one,
    input wire logic       status_load_pulse,
    // Processor side
    input wire logic       cycle_begin,
    input wire logic       read_window,
    input wire logic       bus_release_n,
    input wire logic [7:0] cpu_data_in,
    input wire logic       status_m1,
    // Buffer and commands
    input wire logic       cpu_data_oe,
    input wire logic       sys_data_oe,
    input wire logic       mem_read_n,
    input wire logic       mem_write_n,
    input wire logic       port_read_n,
    input wire logic       port_write_n,
    input wire logic       irq_ack_cmd_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Phase one burst: four reference clocks high, then low
    sequence s_ph1_burst; phase_one [*4] ##1 !phase_one; endsequence
    property p_no_overlap; !(phase_one && phase_two); endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("phase clocks overlap");
    property p_ph1_width; $fell(early_phase_one) |-> s_ph1_burst; endproperty
    a_ph1_width: assert property (p_ph1_width) else $error("phase one width");
    property p_period; $fell(early_phase_one) |-> ##20 $fell(early_phase_one); endproperty
    a_period: assert property (p_period) else $error("clock period");
    property p_ph2_width; $rose(phase_two) |-> ##9 phase_two ##1 !phase_two; endproperty
    a_ph2_width: assert property (p_ph2_width) else $error("phase two width");
    property p_early; $rose(early_phase_one) |=> early_phase_one ##1 !early_phase_one; endproperty
    a_early: assert property (p_early) else $error("early phase one width");
    property p_load;
        status_load_pulse |-> $past(cycle_begin) && $rose(early_phase_one) ##1 !status_load_pulse;
    endproperty
    a_load: assert property (p_load) else $error("status load pulse timing");
    property p_latch; status_load_pulse |-> status_m1 == $past(cpu_data_in[5]); endproperty
    a_latch: assert property (p_latch) else $error("status not captured");
    property p_hold; !status_load_pulse |-> $stable(status_m1); endproperty
    a_hold: assert property (p_hold) else $error("status changed between loads");
    property p_release;
        !bus_release_n |=> mem_read_n && mem_write_n && port_read_n && port_write_n
            && irq_ack_cmd_n && !cpu_data_oe && !sys_data_oe;
    endproperty
    a_release: assert property (p_release) else $error("active during release");
    property p_rd; !(mem_read_n && port_read_n) |-> $past(read_window); endproperty
    a_rd: assert property (p_rd) else $error("read without read window");
    property p_dir; cpu_data_oe |-> $past(read_window) && !sys_data_oe; endproperty
    a_dir: assert property (p_dir) else $error("buffer direction");
endmodule : cmbc_chk

bind cmbc_top cmbc_chk u_cmbc_chk (.*);

// File: tb/cmbc_sys_dev.sv
// Memory and port model on the system data bus
`timescale 1ns/1ps
module cmbc_sys_dev #(
    parameter logic [7:0] RST_OP = 8'hff  // Restart opcode, plain default
) (
    // Clock
    input  wire logic       ref_clk,
    // Control bus commands
    input  wire logic       mem_read_n,
    input  wire logic       mem_write_n,
    input  wire logic       port_read_n,
    input  wire logic       port_write_n,
    input  wire logic       irq_ack_cmd_n,
    // Data bus
    input  wire logic [7:0] sys_data_out,
    output logic      [7:0] sys_data_in
);
    logic [7:0] mem_q  = 8'h00;
    logic [7:0] port_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    // Writes take the bus while the command is low
    always @(posedge ref_clk) begin
        if (!mem_write_n) mem_q <= sys_data_out;
        if (!port_write_n) port_q <= sys_data_out;
        last_q <= sys_data_in;
    end
    // Released bus toggles so a stale value can never pass for data
    always_comb begin
        if (!mem_read_n) sys_data_in = mem_q;
        else if (!port_read_n) sys_data_in = port_q;
        else if (!irq_ack_cmd_n) sys_data_in = RST_OP;
        else sys_data_in = ~last_q;
    end
endmodule : cmbc_sys_dev

// File: tb/cmbc_top_tb_top.sv
// Self-checking bench for the CPU module bus control block
`timescale 1ns/1ps
module cmbc_top_tb_top;
    logic ref_clk = 1'b0, sys_rst = 1'b1, cycle_begin = 1'b0, read_window = 1'b0;
    logic store_strobe_n = 1'b1, bus_release_n = 1'b1, step_mode = 1'b0, step_go = 1'b0;
    logic hold_req = 1'b1, ready_req = 1'b0;
    logic [7:0] cpu_data_in = 8'h00, sys_data_in, cpu_data_out, sys_data_out, dat;
    logic phase_one, phase_two, early_phase_one, status_load_pulse, cpu_reset, cpu_data_oe;
    logic sys_data_oe, hold_sync, ready_sync, direction_select, mem_read_n, mem_write_n;
    logic port_read_n, port_write_n, irq_ack_cmd_n, status_m1, status_stack;
    logic [7:0] mem_v = 8'h00, port_v = 8'h00;
    logic [7:0] stat_tab [5] = '{8'h00, 8'h80, 8'h10, 8'h40, 8'h01};
    int err_count = 0, checks = 0, seed = 32'h1659, n, p1, p2, ea;
    always #12.5 ref_clk = ~ref_clk;
    cmbc_top u_cmbc_top (.*);
    cmbc_sys_dev u_cmbc_sys_dev (.*);
    // One comparison, counted
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done;
        $display("Counts: %0d compared, %0d mismatched", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    // Inputs always move 2 ns after the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask : cyc
    // Present a status byte until the load pulse takes it
    task automatic load(input logic [7:0] s);
        cpu_data_in = s;
        cycle_begin = 1'b1;
        for (n = 0; n < 40 && status_load_pulse !== 1'b1; n++) cyc(1);
        if (n == 40) begin
            err_count++;
            test_done();
        end
        cycle_begin = 1'b0;
        chk("status_m1", s[5], status_m1);
        chk("status_stack", s[2], status_stack);
    endtask : load
    // One machine cycle: status, then a read or a store, optionally under release
    task automatic op(input logic [7:0] s, input logic rd, input logic rel);
        int e;
        bus_release_n = !rel;
        load(s);
        dat = 8'($random(seed));
        cpu_data_in = dat;
        read_window = rd;
        store_strobe_n = rd;
        cyc(4);
        e = rel ? 5'h1f : {~(rd & s[7]), ~(!rd & !s[4]), ~(rd & s[6]), ~(!rd & s[4]), ~(rd & s[0])};
        chk("commands", 8'(e), {mem_read_n, mem_write_n, port_read_n, port_write_n, irq_ack_cmd_n});
        chk("oe", rel ? 0 : (rd ? 2 : 1), {cpu_data_oe, sys_data_oe});
        chk("direction_select", rd, direction_select);
        if (rd && !rel) chk("cpu_data_out", s[7] ? mem_v : s[6] ? port_v : 8'hff, cpu_data_out);
        read_window = 1'b0;
        store_strobe_n = 1'b1;
        bus_release_n = 1'b1;
        cyc(2);
        if (!rd && !rel && s[4]) port_v = dat;
        if (!rd && !rel && !s[4]) mem_v = dat;
        chk("stored", s[4] ? port_v : mem_v, s[4] ? u_cmbc_sys_dev.port_q : u_cmbc_sys_dev.mem_q);
    endtask : op
    initial begin
        repeat (8) @(posedge ref_clk);
        #2 sys_rst = 1'b0;
        for (n = 0; n < 40 && cpu_reset === 1'b1; n++) cyc(1);
        chk("cpu_reset", 15, n);
        p1 = 0;
        p2 = 0;
        ea = 0;
        // Two full clock periods of high-time counts
        repeat (40) begin
            cyc(1);
            p1 += phase_one;
            p2 += phase_two;
            ea += early_phase_one;
        end
        chk("phase_one", 4 * (cmbc_pkg::PH1_END - cmbc_pkg::PH1_START + 1), p1);
        chk("phase_two", 4 * (cmbc_pkg::PH2_END - cmbc_pkg::PH2_START + 1), p2);
        chk("early_phase_one", 4, ea);
        chk("hold_sync", hold_req, hold_sync);
        chk("ready_sync", ready_req, ready_sync);
        $display("phase test done");
        // Single step: ready passes once per press; hold follows a random request
        hold_req = 1'($random(seed));
        ready_req = 1'b1;
        step_mode = 1'b1;
        cyc(22);
        chk("hold_sync", hold_req, hold_sync);
        chk("ready_sync", 0, ready_sync);
        step_go = 1'b1;
        cyc(1);
        step_go = 1'b0;
        cyc(22);
        chk("ready_sync", 1, ready_sync);
        cycle_begin = 1'b1;
        cyc(42);
        cycle_begin = 1'b0;
        chk("ready_sync", 0, ready_sync);
        step_mode = 1'b0;
        $display("step test done");
        foreach (stat_tab[i]) op(stat_tab[i] | (8'($random(seed)) & 8'h24), (stat_tab[i] & 8'hc1) != 0, 1'b0);
        $display("command test done");
        op(8'ha4, 1'b1, 1'b1);
        op(8'h10, 1'b0, 1'b1);
        $display("release test done");
        test_done();
    end
endmodule : cmbc_top_tb_top
